// ---- motion_port_defines.svh ----
// Constants shared by both ends of the motion host command port
`ifndef MOTION_PORT_DEFINES_SVH
`define MOTION_PORT_DEFINES_SVH

`define CLK_MHZ 50
// Busy time per serviced exchange, kept well under the 100 us ceiling
`define BUSY_US 20
`define BUSY_MAX_US 100
`define BUSY_CYCLES (`BUSY_US * `CLK_MHZ)
// Reset must finish under 1.5 ms; we take 1000 us
`define RESET_US 1000
`define RESET_CYCLES (`RESET_US * `CLK_MHZ)

`define STATUS_BUSY_BIT 0
`define ZERO_NARROW 8'h80
`define ZERO_WIDE 12'h800
`define RESET_MASK 8'h3e
`define MASK_FIELD 8'h7e

`define CMD_RESET 8'h00
`define CMD_START 8'h01
`define CMD_HOME 8'h02
`define CMD_INDEX 8'h03
`define CMD_APPLY_FILTER 8'h04
`define CMD_NARROW 8'h05
`define CMD_WIDE 8'h06
`define CMD_RD_DVEL 8'h07
`define CMD_RD_DPOS 8'h08
`define CMD_RD_IPOS 8'h09
`define CMD_RD_APOS 8'h0a
`define CMD_RD_AVEL 8'h0b
`define CMD_RD_SIGS 8'h0c
`define CMD_RD_SUM 8'h0d
`define CMD_ERR_STOP 8'h1a
`define CMD_ERR_INT 8'h1b
`define CMD_MASK 8'h1c
`define CMD_CLEAR_INT 8'h1d
`define CMD_LOAD_FILTER 8'h1e
`define CMD_LOAD_TRAJ 8'h1f
`define CMD_BP_ABS 8'h20
`define CMD_BP_REL 8'h21

// Host-side AXI4-Lite register byte addresses
`define REG_CTRL 8'h00
`define REG_DATA_WR 8'h04
`define REG_STATUS 8'h08
`define REG_DATA_RD 8'h0c
`define CTRL_GO_BIT 0
`define CTRL_PS_BIT 1
`define CTRL_RD_BIT 2

`endif

// ---- motion_port_pkg.sv ----
// Types shared by both ends of the motion host command port
package motion_port_pkg;
    typedef enum logic [2:0] {
        cat_init, cat_interrupt, cat_filter, cat_trajectory, cat_report, cat_unknown
    } cmd_category_t;
    typedef enum logic [1:0] {
        out_narrow, out_wide, out_pwm
    } out_form_t;
endpackage

// ---- motion_port_if.sv ----
// Parallel host port joining the host end and the device end
`timescale 1ns/100ps
interface motion_port_if;
    logic port_select;
    logic wr_n;
    logic rd_n;
    logic [7:0] host_data;
    logic host_data_oe;
    logic [7:0] dev_data;
    logic dev_data_oe;
    modport device (
        input port_select, wr_n, rd_n, host_data, host_data_oe,
        output dev_data, dev_data_oe
    );
    modport host (
        output port_select, wr_n, rd_n, host_data, host_data_oe,
        input dev_data, dev_data_oe
    );
endinterface

// ---- motion_port_device.sv ----
// Device end: command decode, data sequencing, busy pacing and motor output
`timescale 1ns/100ps
`include "motion_port_defines.svh"
module motion_port_device
    import motion_port_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Host port
    motion_port_if.device port,
    // Variant and motion inputs
    input wire logic pwm_variant,
    input wire logic [31:0] actual_position,
    // Motor output
    output logic [7:0] motor_data,
    output logic demux_hi,
    output logic demux_lo,
    output logic pwm_mag,
    output logic pwm_sign,
    // Visible state
    output logic [7:0] status_byte,
    output logic [7:0] interrupt_mask,
    output logic wide_output,
    output logic [31:0] home_offset,
    output logic [2:0] last_category,
    output logic reset_active
);
    ////////////////////////////////////////////////////////////////////////
    logic wr_q, rd_q, ps_q;
    logic wr_rise, rd_fall, rd_rise;
    logic busy;
    logic [15:0] busy_cnt;
    logic [15:0] reset_cnt;
    logic [7:0] cur_cmd;
    logic [3:0] bytes_left;
    logic byte_phase;
    logic [7:0] data_hi;
    logic [11:0] motor_code;
    logic [7:0] pwm_cnt;
    logic [159:0] param_buf;
    logic [31:0] report_word;
    logic start_reset;
    logic [7:1] event_flags;
    logic [3:0] next_count;
    cmd_category_t next_cat;

    assign wr_rise = ~wr_q & port.wr_n;
    assign rd_fall = rd_q & ~port.rd_n;
    assign rd_rise = ~rd_q & port.rd_n;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            ps_q <= 1'b0;
        end else begin
            wr_q <= port.wr_n;
            rd_q <= port.rd_n;
            ps_q <= port.port_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Category and data-count decode
    always_comb begin
        next_cat = cat_unknown;
        next_count = 4'h0;
        case (port.host_data)
            `CMD_RESET, `CMD_HOME, `CMD_NARROW, `CMD_WIDE: next_cat = cat_init;
            `CMD_INDEX: next_cat = cat_interrupt;
            `CMD_ERR_STOP, `CMD_ERR_INT, `CMD_MASK, `CMD_CLEAR_INT: begin
                next_cat = cat_interrupt;
                next_count = 4'h2;
            end
            `CMD_BP_ABS, `CMD_BP_REL: begin
                next_cat = cat_interrupt;
                next_count = 4'h4;
            end
            `CMD_LOAD_FILTER: begin
                next_cat = cat_filter;
                next_count = 4'ha;
            end
            `CMD_APPLY_FILTER: next_cat = cat_filter;
            `CMD_LOAD_TRAJ: begin
                next_cat = cat_trajectory;
                next_count = 4'he;
            end
            `CMD_START: next_cat = cat_trajectory;
            `CMD_RD_DVEL, `CMD_RD_DPOS, `CMD_RD_IPOS, `CMD_RD_APOS: begin
                next_cat = cat_report;
                next_count = 4'h4;
            end
            `CMD_RD_AVEL, `CMD_RD_SIGS, `CMD_RD_SUM: begin
                next_cat = cat_report;
                next_count = 4'h2;
            end
            default: next_cat = cat_unknown;
        endcase
    end

    assign start_reset = wr_rise && !ps_q && !busy && port.host_data == `CMD_RESET;

    ////////////////////////////////////////////////////////////////////////
    // Command capture, data sequencing and busy pacing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            busy_cnt <= 16'h0000;
            cur_cmd <= 8'h00;
            bytes_left <= 4'h0;
            byte_phase <= 1'b0;
            data_hi <= 8'h00;
            last_category <= 3'h0;
        end else if (busy) begin
            // Strobes during busy are dropped, commands included
            if (busy_cnt == 16'h0000) begin
                busy <= 1'b0;
            end else begin
                busy_cnt <= busy_cnt - 16'h0001;
            end
        end else if (wr_rise && !ps_q) begin
            cur_cmd <= port.host_data;
            last_category <= 3'(next_cat);
            bytes_left <= next_count;
            byte_phase <= 1'b0;
            busy <= 1'b1;
            busy_cnt <= 16'(`BUSY_CYCLES - 1);
        end else if ((wr_rise || rd_rise) && ps_q) begin
            if (bytes_left != 4'h0) begin
                byte_phase <= ~byte_phase;
                bytes_left <= bytes_left - 4'h1;
                if (!byte_phase) begin
                    data_hi <= port.host_data;
                end else begin
                    busy <= 1'b1;
                    busy_cnt <= 16'(`BUSY_CYCLES - 1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parameter buffers, mask, output size and home
    always_ff @(posedge aclk) begin
        if (!aresetn || reset_cnt != 16'h0000) begin
            param_buf <= '0;
            interrupt_mask <= `RESET_MASK;
            wide_output <= 1'b0;
            event_flags <= 7'h00;
        end else if (!busy && wr_rise && ps_q && bytes_left != 4'h0) begin
            param_buf <= {param_buf[151:0], port.host_data};
            if (byte_phase && cur_cmd == `CMD_MASK) begin
                interrupt_mask <= port.host_data & `MASK_FIELD;
            end
            if (byte_phase && cur_cmd == `CMD_CLEAR_INT) begin
                event_flags <= event_flags & port.host_data[7:1];
            end
        end else if (!busy && wr_rise && !ps_q) begin
            if (port.host_data == `CMD_NARROW) begin
                wide_output <= 1'b0;
            end else if (port.host_data == `CMD_WIDE && !pwm_variant) begin
                wide_output <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            home_offset <= 32'h0000_0000;
            reset_cnt <= 16'(`RESET_CYCLES - 1);
        end else if (start_reset) begin
            reset_cnt <= 16'(`RESET_CYCLES - 1);
        end else begin
            if (reset_cnt != 16'h0000) begin
                reset_cnt <= reset_cnt - 16'h0001;
            end
            if (reset_cnt == 16'h0001) begin
                home_offset <= actual_position;
            end else if (!busy && wr_rise && !ps_q && port.host_data == `CMD_HOME) begin
                home_offset <= actual_position;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_active <= 1'b1;
            status_byte <= 8'h00;
        end else begin
            reset_active <= reset_cnt != 16'h0000;
            status_byte <= {event_flags, busy || reset_cnt != 16'h0000};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host read path: status in hardware, report bytes picked by bytes_left: 4-byte reads give 15:8, 23:16, 31:24, then 7:0
    always_comb begin
        case (cur_cmd)
            `CMD_RD_DPOS, `CMD_RD_APOS: report_word = actual_position - home_offset;
            default: report_word = {24'h000000, status_byte};
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port.dev_data <= 8'h00;
            port.dev_data_oe <= 1'b0;
        end else if (rd_fall && !ps_q) begin
            port.dev_data <= status_byte;
            port.dev_data_oe <= 1'b1;
        end else if (rd_fall && ps_q) begin
            port.dev_data <= bytes_left[1] ? report_word[31:24] : report_word[15:8];
            if (bytes_left[0] == 1'b1) begin
                port.dev_data <= bytes_left[1] ? report_word[23:16] : report_word[7:0];
            end
            port.dev_data_oe <= 1'b1;
        end else if (rd_rise) begin
            port.dev_data_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Motor output: zero torque held since filter arithmetic is elsewhere
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            motor_code <= `ZERO_WIDE;
            motor_data <= 8'h80;
            demux_hi <= 1'b0;
            demux_lo <= 1'b0;
            pwm_cnt <= 8'h00;
            pwm_mag <= 1'b0;
            pwm_sign <= 1'b0;
        end else begin
            if (reset_cnt != 16'h0000) begin
                motor_code <= `ZERO_WIDE;
            end else begin
                motor_code <= wide_output ? `ZERO_WIDE : {`ZERO_NARROW, 4'h0};
            end
            pwm_cnt <= pwm_cnt + 8'h01;
            if (wide_output) begin
                // Alternate high and low halves for the external latch
                demux_hi <= ~pwm_cnt[0];
                demux_lo <= pwm_cnt[0];
                motor_data <= pwm_cnt[0] ? {2'b00, motor_code[5:0]} : {2'b00, motor_code[11:6]};
            end else begin
                demux_hi <= 1'b0;
                demux_lo <= 1'b0;
                motor_data <= motor_code[11:4];
            end
            // Sign from the offset-binary top bit, magnitude as duty
            pwm_sign <= pwm_variant & ~motor_code[11];
            pwm_mag <= pwm_variant && ({1'b0, pwm_cnt[6:0]} < {1'b0, motor_code[10:4] ^ {7{~motor_code[11]}}});
        end
    end
endmodule // motion_port_device

// ---- motion_port_host.sv ----
// Host end: AXI4-Lite orders turned into paced parallel-port exchanges
`timescale 1ns/100ps
`include "motion_port_defines.svh"
module motion_port_host
    import motion_port_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device port
    motion_port_if.host port
);
    typedef enum {st_idle, st_poll_lo, st_poll_hi, st_xfer_lo, st_xfer_hi, st_gap} host_state_t;
    host_state_t state;
    logic [7:0] ctrl;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic [7:0] last_status;
    logic [3:0] phase;
    logic aw_hold, w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;

    ////////////////////////////////////////////////////////////////////////
    // AXI write: address and data in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            ctrl <= 8'h00;
            wr_byte <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (state == st_gap && phase == 4'h0) begin
                ctrl[`CTRL_GO_BIT] <= 1'b0;
            end
            if (aw_hold && w_hold && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                if (aw_addr == `REG_CTRL && s_axi_wstrb[0] && state == st_idle) begin
                    ctrl <= w_data[7:0];
                end else if (aw_addr == `REG_DATA_WR && s_axi_wstrb[0]) begin
                    wr_byte <= w_data[7:0];
                end else if (aw_addr != `REG_STATUS && aw_addr != `REG_DATA_RD && aw_addr != `REG_CTRL) begin
                    s_axi_bresp <= 2'b10;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            if (s_axi_araddr == `REG_CTRL) begin
                s_axi_rdata <= {24'h0, ctrl};
            end else if (s_axi_araddr == `REG_STATUS) begin
                s_axi_rdata <= {23'h0, state != st_idle, last_status};
            end else if (s_axi_araddr == `REG_DATA_RD) begin
                s_axi_rdata <= {24'h0, rd_byte};
            end else if (s_axi_araddr == `REG_DATA_WR) begin
                s_axi_rdata <= {24'h0, wr_byte};
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One byte exchange: poll busy, then strobe low for 7 cycles and hold for 4 after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= st_idle;
            phase <= 4'h0;
            port.port_select <= 1'b0;
            port.wr_n <= 1'b1;
            port.rd_n <= 1'b1;
            port.host_data <= 8'h00;
            port.host_data_oe <= 1'b0;
            rd_byte <= 8'h00;
            last_status <= 8'h00;
        end else begin
            phase <= phase + 4'h1;
            case (state)
                st_idle: begin
                    phase <= 4'h0;
                    if (ctrl[`CTRL_GO_BIT]) begin
                        state <= st_poll_lo;
                        port.port_select <= 1'b0;
                    end
                end
                st_poll_lo: begin
                    port.rd_n <= 1'b0;
                    if (phase == 4'h7) begin
                        state <= st_poll_hi;
                        last_status <= port.dev_data;
                        port.rd_n <= 1'b1;
                        phase <= 4'h0;
                    end
                end
                st_poll_hi: begin
                    if (phase == 4'h3) begin
                        phase <= 4'h0;
                        if (last_status[`STATUS_BUSY_BIT]) begin
                            state <= st_poll_lo;
                        end else begin
                            state <= st_xfer_lo;
                            port.port_select <= ctrl[`CTRL_PS_BIT];
                            port.host_data <= wr_byte;
                            port.host_data_oe <= ~ctrl[`CTRL_RD_BIT];
                        end
                    end
                end
                st_xfer_lo: begin
                    port.wr_n <= ctrl[`CTRL_RD_BIT];
                    port.rd_n <= ~ctrl[`CTRL_RD_BIT];
                    if (phase == 4'h7) begin
                        state <= st_xfer_hi;
                        phase <= 4'h0;
                        if (ctrl[`CTRL_RD_BIT]) begin
                            rd_byte <= port.dev_data;
                        end
                        port.wr_n <= 1'b1;
                        port.rd_n <= 1'b1;
                    end
                end
                st_xfer_hi: begin
                    if (phase == 4'h3) begin
                        port.host_data_oe <= 1'b0;
                        port.port_select <= 1'b0;
                        state <= st_gap;
                        phase <= 4'h0;
                    end
                end
                default: begin
                    if (phase == 4'h0) begin
                        state <= st_idle;
                    end
                end
            endcase
        end
    end
endmodule // motion_port_host

// ---- motion_port_assertions.sv ----
// Checker for the parallel port joining the host and device ends
`timescale 1ns/100ps
module motion_port_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Port signals
    input wire logic port_select,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [7:0] host_data,
    input wire logic host_data_oe,
    input wire logic [7:0] dev_data,
    input wire logic dev_data_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] since_cmd;
    logic [15:0] since_any;
    logic [2:0] rd_low;
    logic cmd_seen;
    logic idle_polled;
    // Status is sampled well inside the read strobe, past the one-cycle lag
    wire status_ok = !port_select && rd_low == 3'd4;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_cmd <= '0;
            cmd_seen <= 1'b0;
        end else if ($rose(wr_n) && !port_select) begin
            since_cmd <= '0;
            cmd_seen <= 1'b1;
        end else if (since_cmd != 16'hffff) begin
            since_cmd <= since_cmd + 16'h1;
        end
    end
    // Any strobe other than a status read may start a busy period
    always_ff @(posedge aclk) begin
        if (!aresetn || $rose(wr_n) || ($rose(rd_n) && port_select)) since_any <= '0;
        else if (since_any != 16'hffff) since_any <= since_any + 16'h1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || rd_n) rd_low <= '0;
        else if (rd_low != 3'd7) rd_low <= rd_low + 3'd1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !wr_n) idle_polled <= 1'b0;
        else if (status_ok) idle_polled <= !dev_data[0];
    end
    ////////////////////////////////////////////////////////////////////////
    sequence write_held;
        !wr_n ##1 !wr_n;
    endsequence
    AST_BUSY_AFTER_CMD: assert property (
        status_ok && since_cmd inside {[16'd3:16'd900]} |-> dev_data[0]) else $error("busy low after command");
    AST_BUSY_BOUNDED: assert property (
        status_ok && cmd_seen && since_any > 16'd5000 |-> !dev_data[0]) else $error("busy held too long");
    AST_POLL_FIRST: assert property (
        $fell(wr_n) && !port_select |-> idle_polled) else $error("command written without idle poll");
    AST_STATUS_DRIVEN: assert property (
        !rd_n [*3] |-> dev_data_oe) else $error("read not answered");
    AST_STATUS_RELEASED: assert property (
        rd_n [*3] |-> !dev_data_oe) else $error("device drives without read");
    AST_ONE_DRIVER: assert property (
        !(host_data_oe && dev_data_oe)) else $error("both ends drive");
    AST_WRITE_HELD: assert property (
        write_held |-> $stable(host_data) && $stable(port_select) && host_data_oe) else $error("write moved");
    AST_STROBE_LEN: assert property (
        $fell(wr_n) |-> !wr_n [*7]) else $error("write strobe short");
    AST_NO_OVERLAP: assert property (
        !(!wr_n && !rd_n)) else $error("read and write overlap");
endmodule // motion_port_assertions

// ---- motion_host_command_port_test.sv ----
// Self-checking bench joining host and device ends over the parallel port
`timescale 1ns/100ps
module motion_host_command_port_test;
    import motion_port_pkg::*;
    logic aclk, aresetn, pwm_variant, wide_output, reset_active, demux_hi, demux_lo;
    logic [31:0] actual_position, home_offset, s_axi_wdata, s_axi_rdata, v;
    logic [7:0] s_axi_awaddr, s_axi_araddr, motor_data, interrupt_mask, got, b;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [3:0] s_axi_wstrb;
    logic [2:0] last_category;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int miscompares, compares;
    motion_port_if bus();
    motion_port_host motion_port_host_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .port(bus));
    motion_port_device motion_port_device_inst (.aclk, .aresetn, .port(bus), .pwm_variant, .actual_position,
        .motor_data, .demux_hi, .demux_lo, .pwm_mag(), .pwm_sign(), .status_byte(), .interrupt_mask,
        .wide_output, .home_offset, .last_category, .reset_active);
    motion_port_assertions motion_port_assertions_inst (.aclk, .aresetn, .port_select(bus.port_select),
        .wr_n(bus.wr_n), .rd_n(bus.rd_n), .host_data(bus.host_data), .host_data_oe(bus.host_data_oe),
        .dev_data(bus.dev_data), .dev_data_oe(bus.dev_data_oe));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    function automatic logic [2:0] cat_of(input logic [7:0] c);
        if (c inside {8'h00, 8'h02, 8'h05, 8'h06}) return cat_init;
        if (c inside {8'h03, [8'h1a:8'h1d], 8'h20, 8'h21}) return cat_interrupt;
        if (c inside {8'h04, 8'h1e}) return cat_filter;
        if (c inside {8'h01, 8'h1f}) return cat_trajectory;
        if (c inside {[8'h07:8'h0d]}) return cat_report;
        return cat_unknown;
    endfunction
    // Each channel is released at the edge that takes it
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One paced port exchange; the host end polls the device busy flag itself
    task automatic xfer(input logic ps, input logic rd, input logic [7:0] d, output logic [7:0] q);
        logic [31:0] st;
        logic [1:0] rs;
        if (!rd) axi_wr(8'h04, {24'h0, d}, rs);
        axi_wr(8'h00, {29'h0, rd, ps, 1'b1}, rs);
        do begin
            axi_rd(8'h08, st, rs);
        end while (st[8] !== 1'b0);
        axi_rd(8'h0c, st, rs);
        q = st[7:0];
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        #(98000 * 20);
        miscompares++;
        summarize();
    end
    initial begin
        aresetn = 1'b0;
        pwm_variant = 1'b0;
        actual_position = $urandom(32'h85c9486a);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        while (reset_active !== 1'b0) @(posedge aclk);
        check("motor zero", motor_data, 8'h80);
        check("mask", interrupt_mask, 8'h3e);
        check("narrow", wide_output, 1'b0);
        check("home", home_offset, actual_position);
        xfer(1'b0, 1'b1, 8'h00, got);
        check("status busy", got[0], 1'b0);
        $display("test reset done");
        for (int c = 1; c <= 'h21; c++) begin
            if (c > 'h0d && c < 'h1a) continue;
            actual_position <= $urandom();
            xfer(1'b0, 1'b0, 8'(c), got);
            check("category", last_category, cat_of(8'(c)));
            if (c == 2) check("home", home_offset, actual_position);
            if (c == 6) check("wide", wide_output, 1'b1);
            if (c == 6) check("demux", demux_hi ^ demux_lo, 1'b1);
            if (c == 6) check("wide zero", motor_data, demux_hi ? 8'h20 : 8'h00);
        end
        xfer(1'b0, 1'b0, 8'h05, got);
        check("narrow", wide_output, 1'b0);
        pwm_variant <= 1'b1;
        xfer(1'b0, 1'b0, 8'h06, got);
        check("pwm narrow", wide_output, 1'b0);
        pwm_variant <= 1'b0;
        $display("test commands done");
        // Low byte second; bits 0 and 7 of it must not reach the mask
        b = 8'($urandom()) | 8'h81;
        xfer(1'b0, 1'b0, 8'h1c, got);
        xfer(1'b1, 1'b0, ~b, got);
        xfer(1'b1, 1'b0, b, got);
        check("mask", interrupt_mask, b & 8'h7e);
        xfer(1'b1, 1'b0, ~b, got);
        xfer(1'b1, 1'b0, ~b, got);
        check("surplus", interrupt_mask, b & 8'h7e);
        $display("test mask done");
        axi_rd(8'h10, v, r);
        check("rd resp", r, 2'b10);
        axi_wr(8'h14, 32'h0, r);
        check("wr resp", r, 2'b10);
        $display("test unmapped done");
        summarize();
    end
endmodule // motion_host_command_port_test
